/* File: bench/swc_dma_model.sv */
`default_nettype none
module swc_dma_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        xferStart,
  input  wire logic        xferAbort,
  input  wire logic        flushReq,
  input  wire logic [15:0] delay,
  input  wire logic        errEn,
  input  wire logic [1:0]  errCode,
  output logic             xferDone,
  output logic             xferErr,
  output logic [1:0]       xferErrCode,
  output logic [47:0]      xferErrLba,
  output logic             flushDone
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // engine: delay cycles per transfer, one error when asked
  // ------------------------------------------------------------
  logic [15:0] left_ff;
  logic        busy_ff;
  logic        hit;
  assign hit = busy_ff && errEn && left_ff == 16'h0002;
  always_ff @(posedge clk)
  begin
    xferDone <= busy_ff && left_ff == 16'h0001;
    xferErr <= hit;
    // off-pulse values toggle, so a stale code is never read
    xferErrCode <= rst ? 2'h0 : (hit ? errCode : ~xferErrCode);
    xferErrLba <= rst ? 48'h0 : (hit ? 48'h00abcd123456 : ~xferErrLba);
    flushDone <= flushReq && !flushDone;
    left_ff <= xferStart ? delay : left_ff - 16'h0001;
    if (rst || xferAbort)
      busy_ff <= 1'b0;
    else if (xferStart)
      busy_ff <= 1'b1;
    else if (left_ff == 16'h0001)
      busy_ff <= 1'b0;
  end
endmodule // swc_dma_model
`default_nettype wire

/* File: bench/swc_stream_write_cmd_tb.sv */
`default_nettype none
module swc_stream_write_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 1;
  logic        arvalid = 0, rready = 1, errEn = 0, abortSeen, flushSeen;
  logic        awready, wready, bvalid, arready, rvalid, xferStart, irq;
  logic        xferUrgent, xferAbort, xferDone, xferErr, flushReq;
  logic        flushDone, cmdIntrq;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rr, br, xferErrCode, errCode = 0;
  logic [47:0] xferLba, xferErrLba;
  logic [16:0] xferCount;
  logic [2:0]  xferSid;
  logic [15:0] delay = 16'h0008;
  logic [7:0]  logBit [3] = '{8'h80, 8'h10, 8'h04};
  int          badCount = 0, numChecks = 0, n;
  swc_stream_write_cmd #(.MIN_LIMIT_US(2), .CYC_PER_US(4))
    u_swc_stream_write_cmd (.*);
  swc_dma_model u_swc_dma_model (.*);
  always #2 clk = ~clk;
  // ------------------------------------------------------------
  // bus tasks: sample at negedge, act after the next rising edge
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] got,
                     input logic [47:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      br = bresp;
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    while (!b);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk);
      if (ar)
        arvalid <= 1'b0;
    end
    while (!r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), rv & m, e);
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] p,
                     input logic [7:0] c, input logic [15:0] dl,
                     input logic e);
    delay <= dl;
    errEn <= e;
    wr(swc_pkg::OFS_FEAT_CUR, {24'h0, f});
    wr(swc_pkg::OFS_FEAT_PREV, {24'h0, p});
    wr(swc_pkg::OFS_SCNT_LO, {24'h0, c});
    wr(swc_pkg::OFS_SCNT_HI, 32'h0);
    wr(swc_pkg::OFS_COMMAND, {24'h0, swc_pkg::CMD_OPCODE});
    abortSeen = 0;
    flushSeen = 0;
    for (n = 0; n < 2000; n++)
    begin
      @(negedge clk);
      abortSeen |= xferAbort;
      flushSeen |= flushReq;
      if (cmdIntrq)
        break;
    end
    chk("intrq", n < 2000, 1'b1);
    @(posedge clk);
    $display("command %h done after %0d cycles", f, n);
  endtask
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    #300000;
    badCount++;
    tallyAndFinish;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(swc_pkg::OFS_UNIT, 32'hffffffff, 32'h1);
    rd(8'h40);
    chk("unmapped", rr, swc_pkg::RESP_SLV);
    wr(8'h40, 32'h0);
    chk("unmapped wr", br, swc_pkg::RESP_SLV);
    // partial strobes write zeros
    wstrb <= 4'h3;
    wr(swc_pkg::OFS_UNIT, 32'h5);
    wstrb <= 4'hf;
    chk("wr resp", br, swc_pkg::RESP_OKAY);
    rc(swc_pkg::OFS_UNIT, 32'hffffffff, 32'h0);
    wr(swc_pkg::OFS_UNIT, 32'h1);
    wr(swc_pkg::OFS_IRQ_MASK, 32'h7);
    cmd(8'h25, 8'h0, 8'h0, 16'd400, 1'b0);
    chk("count", xferCount, swc_pkg::CNT_FULL);
    chk("sid", xferSid, 3'h5);
    chk("flush", flushSeen, 1'b1);
    rc(swc_pkg::OFS_STATUS, 32'h7, 32'h0);
    chk("irq", irq, 1'b1);
    wr(swc_pkg::OFS_IRQ_MASK, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(swc_pkg::OFS_IRQ_MASK, 32'h7);
    wr(swc_pkg::OFS_IRQ_STAT, 32'h7);
    chk("irq cleared", irq, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      errCode <= 2'(k);
      cmd(8'h40 | 8'(k), 8'h0, 8'h3, 16'd8, 1'b1);
      chk("count", xferCount, 17'h3);
      chk("abort", abortSeen, 1'b0);
      rc(swc_pkg::OFS_STATUS, 32'h7, 32'h2);
      rc(swc_pkg::OFS_ERRLOG, 32'hff, {24'h0, logBit[k]});
    end
    cmd(8'h00, 8'h0, 8'h1, 16'd8, 1'b1);
    chk("abort", abortSeen, 1'b1);
    rc(swc_pkg::OFS_STATUS, 32'h5, 32'h4);
    wr(swc_pkg::OFS_HOB_SEL, 32'h1);
    rc(swc_pkg::OFS_FAIL_LBA, 32'hffffff, 32'h00abcd);
    wr(swc_pkg::OFS_HOB_SEL, 32'h0);
    rc(swc_pkg::OFS_FAIL_LBA, 32'hffffff, 32'h123456);
    cmd(8'h10, 8'h0, 8'h1, 16'd8, 1'b0);
    chk("resume", xferLba, 48'h00abcd123456);
    cmd(8'hc0, 8'h1, 8'h1, 16'd400, 1'b0);
    chk("urgent", xferUrgent, 1'b1);
    chk("time", n <= 16, 1'b1);
    chk("abort", abortSeen, 1'b1);
    rc(swc_pkg::OFS_STATUS, 32'h7, 32'h2);
    rc(swc_pkg::OFS_ERRLOG, 32'h1, 32'h1);
    rc(swc_pkg::OFS_LIMIT, 32'hffffffff, 32'h2);
    wr(swc_pkg::OFS_UNIT, 32'h2);
    cmd(8'h40, 8'h3, 8'h1, 16'd400, 1'b0);
    chk("time", n >= 16 && n <= 32, 1'b1);
    rc(swc_pkg::OFS_LIMIT, 32'hffffffff, 32'h6);
    wr(swc_pkg::OFS_STRM_CFG, 32'h00000302);
    cmd(8'h42, 8'h0, 8'h1, 16'd400, 1'b0);
    rc(swc_pkg::OFS_LIMIT, 32'hffffffff, 32'h3);
    rc(swc_pkg::OFS_STATUS, 32'h7, 32'h2);
    tallyAndFinish;
  end
endmodule // swc_stream_write_cmd_tb
`default_nettype wire

/* File: shared/swc_pkg.sv */
// Contract
// - urgent flag: finish fast, within limit
// - continue-on-error: errors never abort command
// - errors with continue: full transfer, stream error
// - timeout with continue: stop, stream error, timeout
// - always try full transfer before limit
// - flush flag: stream to media before completion
// - resume flag: start at last error address
// - low three feature bits select stream
// - limit is previous feature times unit
// - zero feature uses stored stream default
// - time runs from command write to interrupt
// - short limit is raised to minimum
// - high byte previous; zero means 65536
// - first failing address readable, high select
// - data moves host to device by dma
`default_nettype none
package swc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FEAT_CUR  = 8'h00;
  localparam logic [7:0] OFS_FEAT_PREV = 8'h04;
  localparam logic [7:0] OFS_SCNT_LO   = 8'h08;
  localparam logic [7:0] OFS_SCNT_HI   = 8'h0c;
  localparam logic [7:0] OFS_COMMAND   = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_ERRLOG    = 8'h18;
  localparam logic [7:0] OFS_LIMIT     = 8'h1c;
  localparam logic [7:0] OFS_UNIT      = 8'h20;
  localparam logic [7:0] OFS_STRM_CFG  = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h2c;
  localparam logic [7:0] OFS_LBA_LO    = 8'h30;
  localparam logic [7:0] OFS_LBA_HI    = 8'h34;
  localparam logic [7:0] OFS_HOB_SEL   = 8'h38;
  localparam logic [7:0] OFS_FAIL_LBA  = 8'h3c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int URGENT_BIT   = 7;
  localparam int CONT_ERR_BIT = 6;
  localparam int FLUSH_BIT    = 5;
  localparam int RESUME_BIT   = 4;
  localparam int ST_BUSY      = 0;
  localparam int ST_STRM_ERR  = 1;
  localparam int ST_ERR       = 2;
  localparam int EL_TIMEOUT   = 0;
  localparam int EL_ABRT      = 2;
  localparam int EL_IDNF      = 4;
  localparam int EL_ICRC      = 7;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_TIMEOUT  = 1;
  localparam int IRQ_XERR     = 2;
  // ---------------------------------------------------------------
  // codes, reset values, timing
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_OPCODE = 8'h3a;
  localparam logic [1:0]  EC_ICRC    = 2'h0;
  localparam logic [1:0]  EC_IDNF    = 2'h1;
  localparam logic [1:0]  EC_ABRT    = 2'h2;
  localparam logic [16:0] CNT_FULL   = 17'h10000;
  localparam logic [31:0] UNIT_RST   = 32'h00000001;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int MIN_LIMIT_US  = 1000;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_FLUSH = 2'b11,
    ST_END   = 2'b10
  } swc_state_t;
endpackage
`default_nettype wire

/* File: verilog/swc_stream_write_cmd.sv */
`default_nettype none
module swc_stream_write_cmd #(
  parameter int MIN_LIMIT_US = swc_pkg::MIN_LIMIT_US,
  parameter int CYC_PER_US   = swc_pkg::CYC_PER_US
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             xferStart,
  output logic [47:0]      xferLba,
  output logic [16:0]      xferCount,
  output logic [2:0]       xferSid,
  output logic             xferUrgent,
  output logic             xferAbort,
  input  wire logic        xferDone,
  input  wire logic        xferErr,
  input  wire logic [1:0]  xferErrCode,
  input  wire logic [47:0] xferErrLba,
  output logic             flushReq,
  input  wire logic        flushDone,
  output logic             cmdIntrq,
  output logic             irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [16:0] sectorCount(input logic [7:0] hi,
                                              input logic [7:0] lo);
    sectorCount = ({hi, lo} == 16'h0000) ? swc_pkg::CNT_FULL
                                          : {1'b0, hi, lo};
  endfunction

  function automatic logic [39:0] clampLimit(input logic [39:0] v);
    clampLimit = (v < 40'(MIN_LIMIT_US)) ? 40'(MIN_LIMIT_US) : v;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  swc_pkg::swc_state_t state_ff, nxt_state;
  logic [7:0]  featCur_ff, featPrev_ff, scntLo_ff, scntHi_ff;
  logic [31:0] unit_ff;
  logic [23:0] defLimit_ff [8];
  logic [7:0]  cfgd_ff;
  logic [47:0] errLba_ff [8];
  logic [47:0] startLba_ff, failLba_ff;
  logic        hob_ff, failSeen_ff, anyErr_ff;
  logic [2:0]  status_ff;
  logic [7:0]  errLog_ff;
  logic [2:0]  irqStat_ff, irqMask_ff;
  logic [39:0] limit_ff;
  logic        limitOn_ff, wc_ff, flush_ff;
  logic        awHeld_ff, wHeld_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic        expired;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire       doWr   = awHeld_ff && wHeld_ff && !bvalid;
  wire [7:0] wa     = awAddr_ff;
  wire       wFeatC = doWr && wa == swc_pkg::OFS_FEAT_CUR;
  wire       wFeatP = doWr && wa == swc_pkg::OFS_FEAT_PREV;
  wire       wScLo  = doWr && wa == swc_pkg::OFS_SCNT_LO;
  wire       wScHi  = doWr && wa == swc_pkg::OFS_SCNT_HI;
  wire       wCmd   = doWr && wa == swc_pkg::OFS_COMMAND;
  wire       wUnit  = doWr && wa == swc_pkg::OFS_UNIT;
  wire       wCfg   = doWr && wa == swc_pkg::OFS_STRM_CFG;
  wire       wIrqS  = doWr && wa == swc_pkg::OFS_IRQ_STAT;
  wire       wIrqM  = doWr && wa == swc_pkg::OFS_IRQ_MASK;
  wire       wLbaL  = doWr && wa == swc_pkg::OFS_LBA_LO;
  wire       wLbaH  = doWr && wa == swc_pkg::OFS_LBA_HI;
  wire       wHob   = doWr && wa == swc_pkg::OFS_HOB_SEL;
  wire       wMapped = wFeatC || wFeatP || wScLo || wScHi || wCmd ||
                       wUnit || wCfg || wIrqS || wIrqM || wLbaL ||
                       wLbaH || wHob;
  // register writes other than hob select, irq mask and irq status clear are ignored while a command runs
  wire       idle   = (state_ff == swc_pkg::ST_IDLE);
  wire       start  = wCmd && idle &&
                      wData_ff[7:0] == swc_pkg::CMD_OPCODE;

  // ---------------------------------------------------------------
  // completion time limit
  // ---------------------------------------------------------------
  wire [2:0]  sid     = featCur_ff[2:0];
  wire [39:0] product = 40'(featPrev_ff) * 40'(unit_ff);
  wire [39:0] dfl     = 40'(defLimit_ff[sid]);
  wire        useDfl  = (featPrev_ff == 8'h00);
  wire        dflOn   = cfgd_ff[sid] && dfl != 40'h0;
  wire        limOn   = useDfl ? dflOn : 1'b1;
  wire [39:0] limRaw  = useDfl ? dfl : product;

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  wire running  = (state_ff == swc_pkg::ST_XFER) ||
                  (state_ff == swc_pkg::ST_FLUSH);
  wire timeout  = running && expired;
  wire xErr     = (state_ff == swc_pkg::ST_XFER) && xferErr && !expired;
  wire stopNow  = timeout || (xErr && !wc_ff);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      swc_pkg::ST_IDLE:
        if (start)
          nxt_state = swc_pkg::ST_XFER;
      swc_pkg::ST_XFER:
        if (stopNow)
          nxt_state = swc_pkg::ST_END;
        else if (xferDone)
          nxt_state = flush_ff ? swc_pkg::ST_FLUSH
                               : swc_pkg::ST_END;
      swc_pkg::ST_FLUSH:
        if (timeout || flushDone)
          nxt_state = swc_pkg::ST_END;
      swc_pkg::ST_END:
        nxt_state = swc_pkg::ST_IDLE;
      default:
        nxt_state = swc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= swc_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  swc_us_timer #(.CYC_PER_US(CYC_PER_US)) u_swc_us_timer (
    .clk     (clk),
    .rst     (rst),
    .clr     (start),
    .run     (running),
    .limitOn (limitOn_ff),
    .limit   (limit_ff),
    .expired (expired)
  );

  // ---------------------------------------------------------------
  // command latch and transfer outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      limit_ff   <= 40'h0;
      limitOn_ff <= 1'b0;
      wc_ff      <= 1'b0;
      flush_ff   <= 1'b0;
      xferStart  <= 1'b0;
      xferLba    <= 48'h0;
      xferCount  <= 17'h0;
      xferSid    <= 3'h0;
      xferUrgent <= 1'b0;
    end
    else
    begin
      xferStart <= start;
      if (start)
      begin
        limit_ff   <= clampLimit(limRaw);
        limitOn_ff <= limOn;
        wc_ff      <= featCur_ff[swc_pkg::CONT_ERR_BIT];
        flush_ff   <= featCur_ff[swc_pkg::FLUSH_BIT];
        xferLba    <= featCur_ff[swc_pkg::RESUME_BIT] ? errLba_ff[sid]
                      : startLba_ff;
        xferCount  <= sectorCount(scntHi_ff, scntLo_ff);
        xferSid    <= sid;
        // engine runs minimum-time path; timer bounds it only when a limit is on
        xferUrgent <= featCur_ff[swc_pkg::URGENT_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xferAbort <= 1'b0;
      flushReq  <= 1'b0;
      cmdIntrq  <= 1'b0;
    end
    else
    begin
      xferAbort <= (state_ff == swc_pkg::ST_XFER) && stopNow;
      flushReq  <= (nxt_state == swc_pkg::ST_FLUSH);
      cmdIntrq  <= (state_ff == swc_pkg::ST_END);
    end
  end

  // ---------------------------------------------------------------
  // ending status, error log, failing address
  // ---------------------------------------------------------------
  wire endNow = (state_ff == swc_pkg::ST_END);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_ff   <= 3'h0;
      errLog_ff   <= 8'h00;
      anyErr_ff   <= 1'b0;
      failSeen_ff <= 1'b0;
      failLba_ff  <= 48'h0;
    end
    else if (start)
    begin
      status_ff   <= 3'h1; // busy only
      errLog_ff   <= 8'h00;
      anyErr_ff   <= 1'b0;
      failSeen_ff <= 1'b0;
    end
    else
    begin
      if (xErr)
      begin
        anyErr_ff <= 1'b1;
        errLog_ff[swc_pkg::EL_ICRC] <= errLog_ff[swc_pkg::EL_ICRC] ||
                                       xferErrCode == swc_pkg::EC_ICRC;
        errLog_ff[swc_pkg::EL_IDNF] <= errLog_ff[swc_pkg::EL_IDNF] ||
                                       xferErrCode == swc_pkg::EC_IDNF;
        errLog_ff[swc_pkg::EL_ABRT] <= errLog_ff[swc_pkg::EL_ABRT] ||
                                       xferErrCode == swc_pkg::EC_ABRT;
        if (!failSeen_ff)
        begin
          failSeen_ff <= 1'b1;
          failLba_ff  <= xferErrLba;
        end
      end
      if (timeout)
        errLog_ff[swc_pkg::EL_TIMEOUT] <= 1'b1;
      if (endNow)
      begin
        status_ff[swc_pkg::ST_BUSY]     <= 1'b0;
        status_ff[swc_pkg::ST_STRM_ERR] <= wc_ff &&
          (anyErr_ff || errLog_ff[swc_pkg::EL_TIMEOUT]);
        status_ff[swc_pkg::ST_ERR]      <= !wc_ff &&
          (anyErr_ff || errLog_ff[swc_pkg::EL_TIMEOUT]);
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers and per-stream tables
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      featCur_ff  <= 8'h00;
      featPrev_ff <= 8'h00;
      scntLo_ff   <= 8'h00;
      scntHi_ff   <= 8'h00;
      unit_ff     <= swc_pkg::UNIT_RST;
      cfgd_ff     <= 8'h00;
      startLba_ff <= 48'h0;
      hob_ff      <= 1'b0;
      irqMask_ff  <= 3'h0;
    end
    else if (idle)
    begin
      if (wFeatC) featCur_ff  <= wData_ff[7:0];
      if (wFeatP) featPrev_ff <= wData_ff[7:0];
      if (wScLo)  scntLo_ff   <= wData_ff[7:0];
      if (wScHi)  scntHi_ff   <= wData_ff[7:0];
      if (wUnit)  unit_ff     <= wData_ff;
      if (wCfg)   cfgd_ff[wData_ff[2:0]] <= 1'b1;
      if (wLbaL)  startLba_ff[23:0]  <= wData_ff[23:0];
      if (wLbaH)  startLba_ff[47:24] <= wData_ff[23:0];
      if (wHob)   hob_ff      <= wData_ff[0];
      if (wIrqM)  irqMask_ff  <= wData_ff[2:0];
    end
    else
    begin
      if (wHob)   hob_ff      <= wData_ff[0];
      if (wIrqM)  irqMask_ff  <= wData_ff[2:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (wCfg && idle)
      defLimit_ff[wData_ff[2:0]] <= wData_ff[31:8];
    // first error of the stream's latest failing command feeds a resumed command
    if (xErr && !failSeen_ff)
      errLba_ff[xferSid] <= xferErrLba;
  end

  // ---------------------------------------------------------------
  // interrupts: set wins over write-one clear
  // ---------------------------------------------------------------
  wire [2:0] irqSet = {xErr, timeout, endNow};
  wire [2:0] irqClr = wIrqS ? wData_ff[2:0] : 3'h0;
  always_ff @(posedge clk)
  begin
    if (rst)
      irqStat_ff <= 3'h0;
    else
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign awready = !awHeld_ff;
  assign wready  = !wHeld_ff;
  assign arready = !rvalid;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 32'h0;
      bvalid    <= 1'b0;
      bresp     <= swc_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wHeld_ff <= 1'b1;
        // partial strobes keep it simple: whole word or zeros
        wData_ff <= (wstrb == 4'hf) ? wdata : 32'h0;
      end
      if (doWr)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wMapped ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLV;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  wire [7:0]  ra = {araddr[7:2], 2'b00};
  wire        rMapped = ra == swc_pkg::OFS_STATUS ||
                        ra == swc_pkg::OFS_ERRLOG ||
                        ra == swc_pkg::OFS_LIMIT ||
                        ra == swc_pkg::OFS_UNIT ||
                        ra == swc_pkg::OFS_IRQ_STAT ||
                        ra == swc_pkg::OFS_IRQ_MASK ||
                        ra == swc_pkg::OFS_HOB_SEL ||
                        ra == swc_pkg::OFS_FAIL_LBA;
  wire [23:0] failSel = hob_ff ? failLba_ff[47:24]
                               : failLba_ff[23:0];
  wire [31:0] rMux =
    (ra == swc_pkg::OFS_STATUS)   ? {29'h0, status_ff} :
    (ra == swc_pkg::OFS_ERRLOG)   ? {24'h0, errLog_ff} :
    (ra == swc_pkg::OFS_LIMIT)    ? limit_ff[31:0] :
    (ra == swc_pkg::OFS_UNIT)     ? unit_ff :
    (ra == swc_pkg::OFS_IRQ_STAT) ? {29'h0, irqStat_ff} :
    (ra == swc_pkg::OFS_IRQ_MASK) ? {29'h0, irqMask_ff} :
    (ra == swc_pkg::OFS_HOB_SEL)  ? {31'h0, hob_ff} :
    (ra == swc_pkg::OFS_FAIL_LBA) ? {8'h00, failSel} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= swc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rMux;
      rresp  <= rMapped ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLV;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence sEnding;
    state_ff == swc_pkg::ST_END ##1 cmdIntrq;
  endsequence

  a_stream_id_out: assert property (@(posedge clk)
    disable iff (rst)
    start |=> xferStart && xferSid == $past(featCur_ff[2:0]))
    else $error("stream id not forwarded");
  a_full_count: assert property (@(posedge clk) disable iff (rst)
    start && scntLo_ff == 8'h00 && scntHi_ff == 8'h00
      |=> xferCount == swc_pkg::CNT_FULL)
    else $error("zero count not 65536");
  a_cont_no_abort: assert property (@(posedge clk)
    disable iff (rst)
    xErr && wc_ff && !xferDone
      |=> !xferAbort && state_ff == swc_pkg::ST_XFER)
    else $error("continue-on-error command aborted");
  a_timeout_end: assert property (@(posedge clk) disable iff (rst)
    timeout && wc_ff |=> sEnding ##1 status_ff == 3'h2 &&
      errLog_ff[swc_pkg::EL_TIMEOUT])
    else $error("timeout ending status wrong");
  a_flush_hold: assert property (@(posedge clk) disable iff (rst)
    state_ff == swc_pkg::ST_FLUSH && !flushDone && !expired
      |=> state_ff == swc_pkg::ST_FLUSH && flushReq)
    else $error("completion before flush");
  a_limit_min: assert property (@(posedge clk) disable iff (rst)
    start && limOn |=> limit_ff >= 40'(MIN_LIMIT_US))
    else $error("limit below minimum");
  a_resume_lba: assert property (@(posedge clk) disable iff (rst)
    start && featCur_ff[swc_pkg::RESUME_BIT]
      |=> xferLba == $past(errLba_ff[sid]))
    else $error("resume address wrong");
  a_cont_error: assert property (@(posedge clk) disable iff (rst)
    xErr && wc_ff ##1 xferDone && !expired && !flush_ff
      |=> sEnding ##1 status_ff[swc_pkg::ST_STRM_ERR] &&
        !status_ff[swc_pkg::ST_ERR])
    else $error("continue-on-error ending wrong");
  a_irq_set_wins: assert property (@(posedge clk) disable iff (rst)
    endNow |=> irqStat_ff[swc_pkg::IRQ_DONE])
    else $error("done interrupt lost to clear");
endmodule // swc_stream_write_cmd
`default_nettype wire

/* File: verilog/swc_us_timer.sv */
`default_nettype none
module swc_us_timer #(
  parameter int CYC_PER_US = swc_pkg::CYC_PER_US
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        run,
  input  wire logic        limitOn,
  input  wire logic [39:0] limit,
  output logic             expired
);
  // ---------------------------------------------------------------
  // microsecond prescaler and counter
  // ---------------------------------------------------------------
  logic [15:0] pre_ff;
  logic [39:0] us_ff;
  logic        expired_ff;
  wire         tick = (pre_ff == 16'(CYC_PER_US - 1));

  always_ff @(posedge clk)
  begin
    if (rst || clr)
    begin
      pre_ff <= 16'h0000;
      us_ff  <= 40'h0;
    end
    else if (run)
    begin
      pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
      // saturate so a long command never wraps to early expiry
      if (tick && us_ff != '1)
        us_ff <= us_ff + 40'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || clr)
      expired_ff <= 1'b0;
    else
      expired_ff <= run && limitOn && (us_ff >= limit);
  end
  assign expired = expired_ff;

  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    clr |=> (us_ff == 40'h0 && !expired))
    else $error("timer not cleared by command write");
  a_no_expire_off: assert property (@(posedge clk)
    disable iff (rst) !limitOn |=> !expired)
    else $error("timer expired with limit ignored");
endmodule // swc_us_timer
`default_nettype wire
